// ---- rtl/ret_exec_pkg.sv ----
package ret_exec_pkg;
  localparam int PC_W = 14;
  localparam int SP_W = 3;
  localparam int DP_W = 9;
  localparam int DEPTH = 8;
  localparam logic [9:0] OP_RETURN_SUB = 10'h044;
  localparam logic [9:0] OP_RETURN_SKIP = 10'h045;
  localparam logic [9:0] OP_RETURN_INT = 10'h046;
  localparam logic [9:0] OP_SET_BIT_BASE = 10'h05c;
  localparam logic [9:0] OP_SET_BIT_MASK = 10'h3fc;
  localparam logic [SP_W-1:0] SP_RESET = 3'h7;
  localparam logic [SP_W-1:0] SP_STEP = 3'h1;
  localparam int BIT_SEL_W = 2;
  localparam logic [PC_W-1:0] PC_RESET = 14'h0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SECOND = 2'b01
  } exec_state_t;
endpackage : ret_exec_pkg

// ---- rtl/saved_state_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface saved_state_if;
  import ret_exec_pkg::*;
  logic capture;
  logic restore;
  logic [DP_W-1:0] dp_in;
  logic carry_in;
  logic skip_in;
  logic la_in;
  logic [3:0] a_in;
  logic [3:0] b_in;
  logic [DP_W-1:0] dp_out;
  logic carry_out;
  logic skip_out;
  logic la_out;
  logic [3:0] a_out;
  logic [3:0] b_out;
  modport core (output capture, restore, dp_in, carry_in, skip_in, la_in, a_in, b_in,
                input dp_out, carry_out, skip_out, la_out, a_out, b_out);
  modport store (input capture, restore, dp_in, carry_in, skip_in, la_in, a_in, b_in,
                 output dp_out, carry_out, skip_out, la_out, a_out, b_out);
endinterface : saved_state_if
`default_nettype wire

// ---- rtl/saved_state_store.sv ----
`timescale 1ns/1ps
`default_nettype none
module saved_state_store
  import ret_exec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  saved_state_if.store ss
);
  // Pointer, three flag bits, A and B
  localparam int SAVE_W = DP_W + 11;
  logic [SAVE_W-1:0] save_q;

  // Capture at interrupt entry; the copy stays put until the next entry
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      save_q <= '0;
    end else if (ss.capture) begin
      save_q <= {ss.dp_in, ss.carry_in, ss.skip_in, ss.la_in, ss.a_in, ss.b_in};
    end
  end

  assign {ss.dp_out, ss.carry_out, ss.skip_out, ss.la_out, ss.a_out, ss.b_out} = save_q;
endmodule : saved_state_store
`default_nettype wire

// ---- rtl/return_bitset_exec.sv ----
// Notes on behaviour
// - Return-skip reloads pc, pops, two cycles
// - Return-skip always skips next instruction
// - Interrupt return reloads pc in one cycle
// - Interrupt return restores pointer, flags, A, B
`timescale 1ns/1ps
`default_nettype none
module return_bitset_exec
  import ret_exec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [9:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic [PC_W-1:0] push_addr_i,
  input wire logic push_i,
  input wire logic int_entry_i,
  input wire logic [DP_W-1:0] dp_cur_i,
  input wire logic carry_cur_i,
  input wire logic skip_cur_i,
  input wire logic la_cur_i,
  input wire logic [3:0] a_cur_i,
  input wire logic [3:0] b_cur_i,
  input wire logic [3:0] mem_rdata_i,
  output logic busy_o,
  output logic pc_load_o,
  output logic [PC_W-1:0] pc_o,
  output logic skip_next_o,
  output logic [SP_W-1:0] sp_o,
  output logic restore_o,
  output logic [DP_W-1:0] dp_o,
  output logic carry_o,
  output logic skip_status_o,
  output logic la_state_o,
  output logic [3:0] a_o,
  output logic [3:0] b_o,
  output logic mem_we_o,
  output logic [DP_W-1:0] mem_addr_o,
  output logic [3:0] mem_wdata_o
);
  logic [PC_W-1:0] stack_q [DEPTH];
  logic [SP_W-1:0] sp_q;
  exec_state_t state_q;
  logic is_rts, is_rti, is_sb, take;
  logic pop;
  logic push_ok;
  logic [SP_W-1:0] push_slot;
  saved_state_if ss ();

  saved_state_store u_store (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .ss(ss)
  );

  function automatic logic [3:0] bit_onehot(input logic [BIT_SEL_W-1:0] j);
    bit_onehot = 4'h1 << j;
  endfunction : bit_onehot

  // Opcode classes; one decode feeds the pointer, the stack and the outputs
  function automatic logic is_return_op(input logic [9:0] op);
    is_return_op = (op == OP_RETURN_SUB) || (op == OP_RETURN_SKIP) || (op == OP_RETURN_INT);
  endfunction : is_return_op

  function automatic logic is_two_cycle_op(input logic [9:0] op);
    is_two_cycle_op = (op == OP_RETURN_SUB) || (op == OP_RETURN_SKIP);
  endfunction : is_two_cycle_op

  function automatic logic is_set_bit_op(input logic [9:0] op);
    is_set_bit_op = (op & OP_SET_BIT_MASK) == OP_SET_BIT_BASE;
  endfunction : is_set_bit_op

  assign take = instr_valid_i && (state_q == ST_IDLE);
  assign is_rts = take && (instr_i == OP_RETURN_SKIP);
  assign is_rti = take && (instr_i == OP_RETURN_INT);
  assign is_sb = take && is_set_bit_op(instr_i);
  // Every return pops exactly one level, whatever its length
  assign pop = take && is_return_op(instr_i);
  // A push in a pop cycle is dropped; call and return never share a cycle
  assign push_ok = push_i && !pop;
  assign push_slot = sp_q + SP_STEP;
  // Fetch must hold off while the second cycle of a return runs
  assign busy_o = (state_q != ST_IDLE);

  assign ss.capture = int_entry_i;
  assign ss.restore = is_rti;
  assign ss.dp_in = dp_cur_i;
  assign ss.carry_in = carry_cur_i;
  assign ss.skip_in = skip_cur_i;
  assign ss.la_in = la_cur_i;
  assign ss.a_in = a_cur_i;
  assign ss.b_in = b_cur_i;
  assign sp_o = sp_q;

  // Two-cycle returns: first cycle pops, second finishes
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (take && is_two_cycle_op(instr_i)) state_q <= ST_SECOND;
        ST_SECOND: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Stack pointer; a push from call or interrupt entry and a pop never coincide
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sp_q <= SP_RESET;
    end else if (pop) begin
      sp_q <= sp_q - SP_STEP;
    end else if (push_i) begin
      sp_q <= push_slot;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < DEPTH; i++) stack_q[i] <= PC_RESET;
    end else if (push_ok) begin
      stack_q[push_slot] <= push_addr_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pc_load_o <= 1'b0;
    end else begin
      pc_load_o <= pop;
    end
  end

  // Popped address holds until the next return, so fetch may read it late
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pc_o <= PC_RESET;
    end else if (pop) begin
      pc_o <= stack_q[sp_q];
    end
  end

  // Skip request goes out with the load, whatever the flags say
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      skip_next_o <= 1'b0;
    end else begin
      skip_next_o <= is_rts;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      restore_o <= 1'b0;
    end else begin
      restore_o <= ss.restore;
    end
  end

  // Pointer comes back with the flags so data access resumes where it left off
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dp_o <= '0;
    end else if (ss.restore) begin
      dp_o <= ss.dp_out;
    end
  end

  // Carry only changes on interrupt return; plain return leaves it alone
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      carry_o <= 1'b0;
      skip_status_o <= 1'b0;
      la_state_o <= 1'b0;
    end else if (ss.restore) begin
      carry_o <= ss.carry_out;
      skip_status_o <= ss.skip_out;
      la_state_o <= ss.la_out;
    end
  end

  // Working registers come back as they were just before entry
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      a_o <= 4'h0;
      b_o <= 4'h0;
    end else if (ss.restore) begin
      a_o <= ss.a_out;
      b_o <= ss.b_out;
    end
  end

  // Write strobe lasts one cycle; the memory itself does the store
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_we_o <= 1'b0;
    end else begin
      mem_we_o <= is_sb;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_addr_o <= '0;
    end else if (is_sb) begin
      mem_addr_o <= dp_cur_i;
    end
  end

  // Read-modify-write uses the nibble already read at the current pointer
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_wdata_o <= 4'h0;
    end else if (is_sb) begin
      mem_wdata_o <= mem_rdata_i | bit_onehot(instr_i[BIT_SEL_W-1:0]);
    end
  end
endmodule : return_bitset_exec
`default_nettype wire

// ---- test/return_bitset_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module return_bitset_asserts
  import ret_exec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [9:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic busy_o,
  input wire logic pc_load_o,
  input wire logic skip_next_o,
  input wire logic restore_o,
  input wire logic [SP_W-1:0] sp_o,
  input wire logic [3:0] mem_rdata_i,
  input wire logic mem_we_o,
  input wire logic [3:0] mem_wdata_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // Instructions offered while busy are dropped, so they never count
  wire logic go = instr_valid_i && !busy_o;
  property p_rts;
    go && instr_i == OP_RETURN_SKIP |=> pc_load_o && skip_next_o && busy_o ##1 !pc_load_o;
  endproperty
  a_rts: assert property (p_rts) else $error("skip return");
  property p_rt;
    go && instr_i == OP_RETURN_SUB |=> pc_load_o && !skip_next_o && !restore_o;
  endproperty
  a_rt: assert property (p_rt) else $error("plain return");
  property p_rti;
    go && instr_i == OP_RETURN_INT |=> pc_load_o && restore_o && !busy_o;
  endproperty
  a_rti: assert property (p_rti) else $error("interrupt return");
  property p_rst;
    restore_o |-> $past(go) && $past(instr_i) == OP_RETURN_INT;
  endproperty
  a_rst: assert property (p_rst) else $error("stray restore");
  property p_pop;
    pc_load_o |-> sp_o == $past(sp_o) - 3'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("pointer pop");
  property p_sb;
    go && (instr_i & OP_SET_BIT_MASK) == OP_SET_BIT_BASE |=> mem_we_o &&
      mem_wdata_o == ($past(mem_rdata_i) | 4'h1 << $past(instr_i[1:0]));
  endproperty
  a_sb: assert property (p_sb) else $error("set bit");
  c_rts: cover property (pc_load_o && skip_next_o);
  c_rti: cover property (restore_o);
  c_sb: cover property (mem_we_o);
endmodule : return_bitset_asserts
bind return_bitset_exec return_bitset_asserts u_chk (.ref_clk_i, .resetn_i, .instr_i,
  .instr_valid_i, .busy_o, .pc_load_o, .skip_next_o, .restore_o, .sp_o, .mem_rdata_i,
  .mem_we_o, .mem_wdata_o);
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ret_exec_pkg::*;
  logic ref_clk_i, resetn_i, instr_valid_i, push_i, int_entry_i, carry_cur_i, skip_cur_i;
  logic la_cur_i, busy_o, pc_load_o, skip_next_o, restore_o, carry_o, skip_status_o;
  logic la_state_o, mem_we_o;
  logic [9:0] instr_i;
  logic [PC_W-1:0] push_addr_i, pc_o;
  logic [DP_W-1:0] dp_cur_i, dp_o, mem_addr_o;
  logic [3:0] a_cur_i, b_cur_i, mem_rdata_i, a_o, b_o, mem_wdata_o;
  logic [SP_W-1:0] sp_o;
  int err_count, n_checks;
  return_bitset_exec return_bitset_exec_inst (.ref_clk_i, .resetn_i, .instr_i, .instr_valid_i,
    .push_addr_i, .push_i, .int_entry_i, .dp_cur_i, .carry_cur_i, .skip_cur_i, .la_cur_i,
    .a_cur_i, .b_cur_i, .mem_rdata_i, .busy_o, .pc_load_o, .pc_o, .skip_next_o, .sp_o,
    .restore_o, .dp_o, .carry_o, .skip_status_o, .la_state_o, .a_o, .b_o, .mem_we_o,
    .mem_addr_o, .mem_wdata_o);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic push(input logic [PC_W-1:0] a, input logic ie);
    @(posedge ref_clk_i);
    {push_addr_i, push_i, int_entry_i} <= {a, 1'b1, ie};
    @(posedge ref_clk_i);
    {push_i, int_entry_i} <= 2'b00;
  endtask : push
  // Returns with outputs of the answering edge settled
  task automatic step(input logic [9:0] op);
    @(posedge ref_clk_i);
    {instr_i, instr_valid_i} <= {op, 1'b1};
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask : step
  task automatic scn_returns;
    push(14'h1234, 1'b0);
    push(14'h0abc, 1'b0);
    step(OP_RETURN_SKIP);
    chk({pc_o, sp_o}, {14'h0abc, 3'h0});
    chk({skip_next_o, busy_o}, 2'b11);
    step(OP_RETURN_SUB);
    chk({pc_o, sp_o}, {14'h1234, 3'h7});
    chk({skip_next_o, carry_o, pc_load_o}, 3'b001);
  endtask : scn_returns
  task automatic scn_int_return;
    @(posedge ref_clk_i);
    {dp_cur_i, carry_cur_i, skip_cur_i, la_cur_i, a_cur_i, b_cur_i} <= {9'h1a5, 3'h7, 8'h96};
    push(14'h0155, 1'b1);
    {dp_cur_i, carry_cur_i, skip_cur_i, la_cur_i, a_cur_i, b_cur_i} <= '0;
    step(OP_RETURN_INT);
    chk({pc_o, busy_o, pc_load_o}, {14'h0155, 2'b01});
    chk({restore_o, dp_o, carry_o, skip_status_o, la_state_o}, {1'b1, 9'h1a5, 3'h7});
    chk({a_o, b_o}, 8'h96);
  endtask : scn_int_return
  task automatic scn_set_bit;
    @(posedge ref_clk_i);
    {dp_cur_i, mem_rdata_i} <= {9'h0c3, 4'h2};
    for (int j = 0; j < 4; j++) begin
      step(OP_SET_BIT_BASE + 10'(j));
      chk({mem_we_o, mem_addr_o}, {1'b1, 9'h0c3});
      chk(mem_wdata_o, 4'h2 | 4'h1 << j);
    end
  endtask : scn_set_bit
  // Unknown opcode and an instruction offered in the busy cycle are both dropped
  task automatic scn_refused;
    push(14'h0321, 1'b0);
    step(10'h047);
    chk({pc_load_o, mem_we_o, restore_o, sp_o}, {3'b000, 3'h0});
    @(posedge ref_clk_i);
    {instr_i, instr_valid_i} <= {OP_RETURN_SUB, 1'b1};
    @(posedge ref_clk_i);
    instr_i <= OP_RETURN_INT;
    #1;
    chk({busy_o, pc_load_o, pc_o, sp_o}, {2'b11, 14'h0321, 3'h7});
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b0;
    #1;
    chk({busy_o, pc_load_o, restore_o, sp_o}, {3'b000, 3'h7});
  endtask : scn_refused
  // Mid-run reset clears restored state and the saved copy
  task automatic scn_reset;
    @(posedge ref_clk_i);
    resetn_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk({dp_o, carry_o, a_o, b_o, sp_o}, {9'h000, 1'b0, 8'h00, SP_RESET});
    @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    step(OP_RETURN_INT);
    chk({pc_load_o, restore_o, pc_o, dp_o, sp_o}, {2'b11, PC_RESET, 9'h000, 3'h6});
  endtask : scn_reset
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    {resetn_i, instr_valid_i, push_i, int_entry_i, carry_cur_i, skip_cur_i, la_cur_i} = '0;
    {instr_i, push_addr_i, dp_cur_i, a_cur_i, b_cur_i, mem_rdata_i} = '0;
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    chk(sp_o, SP_RESET);
    scn_returns();
    scn_int_return();
    scn_set_bit();
    scn_refused();
    scn_reset();
    conclude();
  end
endmodule : testbench
`default_nettype wire
